// File: pkg/pin_mux_pkg.sv
// constants for the pin function select and port block
// assumes an apb slave with byte data in the low lane
package pin_mux_pkg;
    localparam int PORT_COUNT = 4;
    localparam int PORT_WIDTH = 8;
    localparam int PORT_A     = 0;
    localparam int PORT_B     = 1;
    localparam int PORT_C     = 2;
    localparam int PORT_F     = 3;
    // register byte addresses
    localparam logic [7:0] ADDR_PF_LOW       = 8'h00;
    localparam logic [7:0] ADDR_PF_HIGH      = 8'h04;
    localparam logic [7:0] ADDR_TIMER_ROUTE  = 8'h08;
    localparam logic [7:0] ADDR_SERIAL_ROUTE = 8'h0C;
    localparam logic [7:0] ADDR_PE_HIGH      = 8'h10;
    localparam logic [7:0] ADDR_BIT_OP       = 8'h14;
    localparam logic [7:0] ADDR_WAKE_EN      = 8'h18;
    localparam logic [3:0] PORT_ROW_BASE     = 4'h2;
    localparam logic [3:0] PORT_DATA_OFS     = 4'h0;
    localparam logic [3:0] PORT_CTRL_OFS     = 4'h4;
    localparam logic [3:0] PORT_PIN_OFS      = 4'h8;
    // implemented bits; the rest read zero
    localparam logic [7:0] PF_LOW_MASK       = 8'hFF;
    localparam logic [7:0] PF_HIGH_MASK      = 8'h3F;
    localparam logic [7:0] TIMER_ROUTE_MASK  = 8'hC9;
    localparam logic [7:0] SERIAL_ROUTE_MASK = 8'h71;
    localparam logic [7:0] PE_HIGH_MASK      = 8'hFF;
    localparam logic [7:0] SELECT_RESET      = 8'h00;
    localparam logic [7:0] PORT_RESET        = 8'hFF;
    // field positions
    localparam int F3_SEL_LSB         = 6;
    localparam int F2_SEL_LSB         = 4;
    localparam int F1_SEL_LSB         = 2;
    localparam int F0_SEL_LSB         = 0;
    localparam int TIMER1_CAPTURE_POS = 6;
    localparam int TIMER2_CLOCK_POS   = 3;
    localparam int SERIAL_DATA_POS    = 5;
    localparam int SERIAL_CLOCK_POS   = 4;
    localparam int BIT_OP_VALUE_POS   = 3;
    localparam int BIT_OP_CTRL_POS    = 4;
    localparam int BIT_OP_PORT_LSB    = 5;
    // selector codes
    localparam logic [1:0] CODE_GPIO   = 2'h0;
    localparam logic [1:0] CODE_LCD    = 2'h1;
    localparam logic [1:0] CODE_ANALOG = 2'h2;
    localparam logic [1:0] CODE_OPAMP  = 2'h3;
endpackage : pin_mux_pkg

// File: test/pin_board.sv
// board model: the package pins seen from outside the device
// assumes active-low output enables, one per pin
`timescale 1ns/1ps
`default_nettype none
module pin_board (
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe_n,
    input  wire logic [31:0] level,
    output logic      [31:0] pin_in
);
    // a driven pin shows its own output, a released one the outside level
    assign pin_in = (pin_out & ~pin_oe_n) | (level & pin_oe_n);
endmodule : pin_board
`default_nettype wire

// File: test/pin_function_select_bench.sv
// self-checking bench for the pin function select block
// assumes a zero-wait apb slave and pins fed back through pin_board
`timescale 1ns/1ps
`default_nettype none
module pin_function_select_bench
    import pin_mux_pkg::*;
;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        low_power = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] level = 32'hFFF7_5E97; // outside levels, port f c b a
    logic [31:0] port_pin_in, port_pin_out, port_pin_oe_n, prdata, rd;
    logic [7:0]  en;
    logic [3:0]  route;
    logic        pready, pslverr, wake, err, seen;
    int          n_errors, comparisons;
    // selector code beside the enables it should give
    logic [15:0] rows [11] = '{16'h4080, 16'h8020, 16'hC000, 16'h1040, 16'h2010,
        16'h0808, 16'h0C02, 16'h0400, 16'h0204, 16'h0301, 16'h0100};
    pin_function_select pin_function_select_i (
        .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr, .port_pin_in, .port_pin_out,
        .port_pin_oe_n, .low_power, .wake, .lcd_segment_24_en(en[7]),
        .lcd_segment_23_en(en[6]), .analog_input_7_en(en[5]), .analog_input_6_en(en[4]),
        .analog_input_5_en(en[3]), .analog_input_4_en(en[2]),
        .opamp_noninverting_input_en(en[1]), .opamp_inverting_input_en(en[0]),
        .timer1_capture_input(route[3]), .timer2_external_clock(route[2]),
        .serial_data_input(route[1]), .serial_clock_input(route[0]));
    pin_board pin_board_i (.pin_out(port_pin_out), .pin_oe_n(port_pin_oe_n),
        .level(level), .pin_in(port_pin_in));
    initial begin
        forever #20 clk = ~clk;
    end
    // one apb transfer; the request holds until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic give_verdict;
        $display("mismatches %0d of %0d comparisons", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        chk("oe_n after reset", 32'hFFFF_FFFF, port_pin_oe_n);
        chk("out after reset", 32'hFFFF_FFFF, port_pin_out);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(32 + 16 * (i / 2) + 4 * (i % 2)), 32'h0);
            chk("port reg reset", 32'hFF, rd);
        end
        foreach (rows[r]) begin
            apb(1'b1, ADDR_PF_LOW, {24'h0, rows[r][15:8]});
            @(negedge clk);
            chk("function enables", {24'h0, rows[r][7:0]}, {24'h0, en});
        end
        apb(1'b1, ADDR_PF_LOW, 32'h0);
        apb(1'b1, ADDR_PF_HIGH, 32'hFF);
        apb(1'b0, ADDR_PF_HIGH, 32'h0);
        chk("unimplemented bits", 32'h3F, rd);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("routes clear", 32'h0, {28'h0, route});
        apb(1'b1, ADDR_TIMER_ROUTE, 32'h48);
        apb(1'b1, ADDR_SERIAL_ROUTE, 32'h30);
        @(negedge clk);
        chk("routes set", 32'hF, {28'h0, route});
        // port c.0 turned to output with the latch untouched must drive high
        apb(1'b1, 8'h44, 32'hFE);
        @(negedge clk);
        chk("port c.0 drive", 32'h2, {30'h0, port_pin_out[16], port_pin_oe_n[16]});
        // set b.0 on data: the other bits take the pin levels, not the ones of the latch
        apb(1'b1, ADDR_BIT_OP, 32'h28);
        apb(1'b0, 8'h30, 32'h0);
        chk("bit set on data", 32'h5F, rd);
        apb(1'b1, ADDR_BIT_OP, 32'h58);
        apb(1'b0, 8'h44, 32'h0);
        chk("bit set on ctrl", 32'hFF, rd);
        // port a.1 and a.0 enabled, a.4 not; a.1 falls while awake, so only a.0 may wake
        apb(1'b1, ADDR_WAKE_EN, 32'h03);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            level[(k == 0) ? 1 : 4 * (k - 1)] <= 1'b0;
            low_power <= (k != 0);
            seen = 1'b0;
            repeat (6) begin
                @(negedge clk);
                seen = seen | (wake === 1'b1);
            end
            chk("wake", 32'(k == 1), {31'h0, seen});
        end
        give_verdict();
    end
endmodule : pin_function_select_bench
`default_nettype wire

// File: verilog/pin_function_select.sv
// pin function select, input routing and port registers behind apb
// assumes a zero-wait apb master on clk; pins are asynchronous
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - port f.3: 00/11 gpio, 01 lcd segment 24, 10 analog input 7
// - port f.2: 00/11 gpio, 01 lcd segment 23, 10 analog input 6
// - port f.1: 00 gpio, 10 analog input 5, 11 opamp non-inverting; 01 reserved
// - port f.0: 00 gpio, 10 analog input 4, 11 opamp inverting; 01 reserved
// - timer 1 capture from port a.3 when bit 6 clear, c.0 when set
// - timer 2 clock from port c.3 when bit 3 clear, a.7 when set
// - serial data in from port a.6 when bit 5 clear, b.3 when set
// - serial clock in from port a.5 when bit 4 clear, b.2 when set
// - reset sets every port data and direction register to all ones
// - output pin with untouched data latch drives high
// - bit set/clear reads whole port, changes one bit, writes byte back
// - in sleep or idle, falling edge on enabled port a pin wakes
// - wake enable is per port a pin, any combination allowed
module pin_function_select
    import pin_mux_pkg::*;
(
    input  wire logic                                  clk,
    input  wire logic                                  resetn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [7:0]                            paddr,
    input  wire logic [31:0]                           pwdata,
    input  wire logic [3:0]                            pstrb,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic [PORT_COUNT-1:0][PORT_WIDTH-1:0] port_pin_in,
    output logic      [PORT_COUNT-1:0][PORT_WIDTH-1:0] port_pin_out,
    output logic      [PORT_COUNT-1:0][PORT_WIDTH-1:0] port_pin_oe_n,
    input  wire logic                                  low_power,
    output logic                                       wake,
    output logic                                       lcd_segment_24_en,
    output logic                                       lcd_segment_23_en,
    output logic                                       analog_input_7_en,
    output logic                                       analog_input_6_en,
    output logic                                       analog_input_5_en,
    output logic                                       analog_input_4_en,
    output logic                                       opamp_noninverting_input_en,
    output logic                                       opamp_inverting_input_en,
    output logic                                       timer1_capture_input,
    output logic                                       timer2_external_clock,
    output logic                                       serial_data_input,
    output logic                                       serial_clock_input
);
    logic [7:0] port_f_low_function_select;
    logic [7:0] port_f_high_function_select;
    logic [7:0] timer_input_pin_routing;
    logic [7:0] serial_input_pin_routing;
    logic [7:0] port_e_high_function_select;
    logic [7:0] wake_enable;
    logic [7:0] next_pf_low;
    logic [7:0] next_pf_high;
    logic [7:0] next_timer_route;
    logic [7:0] next_serial_route;
    logic [7:0] next_pe_high;
    logic [7:0] next_wake_enable;

    logic [PORT_COUNT-1:0][PORT_WIDTH-1:0] port_data;
    logic [PORT_COUNT-1:0][PORT_WIDTH-1:0] port_ctrl;
    logic [PORT_COUNT-1:0][PORT_WIDTH-1:0] pin_level;
    logic [PORT_COUNT-1:0][PORT_WIDTH-1:0] gpio_enable;
    logic [PORT_COUNT-1:0]                 wr_data;
    logic [PORT_COUNT-1:0]                 wr_ctrl;
    logic [PORT_COUNT-1:0]                 bit_op;

    logic       access;
    logic       wr_en;
    logic       port_hit;
    logic [3:0] port_row;
    logic [1:0] port_idx;
    logic       mapped;
    logic [7:0] rd_byte;
    logic [1:0] f3_code;
    logic [1:0] f2_code;
    logic [1:0] f1_code;
    logic [1:0] f0_code;

    // gpio unless a real alternate function is picked; lcd pins treat 11
    // as gpio, opamp pins treat reserved 01 as gpio
    function automatic logic is_gpio(input logic [1:0] code, input logic lcd_pin);
        if (lcd_pin) return (code == CODE_GPIO) || (code == CODE_OPAMP);
        return (code == CODE_GPIO) || (code == CODE_LCD);
    endfunction : is_gpio

    // ---- apb decode; zero wait states, so pready follows access ----
    assign access   = psel && penable;
    assign port_row = paddr[7:4] - PORT_ROW_BASE;
    assign port_idx = port_row[1:0];
    assign port_hit = (paddr[7:4] >= PORT_ROW_BASE) && (port_row < 4'(PORT_COUNT));
    assign wr_en    = access && pwrite && pstrb[0] && mapped;
    assign pready   = access;
    assign pslverr  = access && !mapped;

    // read mux; unimplemented bits read zero because the write masks keep them clear
    always_comb begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        if (paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else if (port_hit) begin
            unique case (paddr[3:0])
                PORT_DATA_OFS: rd_byte = port_data[port_idx];
                PORT_CTRL_OFS: rd_byte = port_ctrl[port_idx];
                PORT_PIN_OFS:  rd_byte = pin_level[port_idx];
                default:       mapped = 1'b0;
            endcase
        end else begin
            unique case (paddr)
                ADDR_PF_LOW:       rd_byte = port_f_low_function_select;
                ADDR_PF_HIGH:      rd_byte = port_f_high_function_select;
                ADDR_TIMER_ROUTE:  rd_byte = timer_input_pin_routing;
                ADDR_SERIAL_ROUTE: rd_byte = serial_input_pin_routing;
                ADDR_PE_HIGH:      rd_byte = port_e_high_function_select;
                ADDR_BIT_OP:       rd_byte = 8'h00;
                ADDR_WAKE_EN:      rd_byte = wake_enable;
                default:           mapped = 1'b0;
            endcase
        end
    end
    assign prdata = {24'h000000, rd_byte};

    // select and routing registers; write masks keep reserved bits zero
    always_comb begin
        next_pf_low       = port_f_low_function_select;
        next_pf_high      = port_f_high_function_select;
        next_timer_route  = timer_input_pin_routing;
        next_serial_route = serial_input_pin_routing;
        next_pe_high      = port_e_high_function_select;
        next_wake_enable  = wake_enable;
        if (wr_en) begin
            unique case (paddr)
                ADDR_PF_LOW:       next_pf_low = pwdata[7:0] & PF_LOW_MASK;
                ADDR_PF_HIGH:      next_pf_high = pwdata[7:0] & PF_HIGH_MASK;
                ADDR_TIMER_ROUTE:  next_timer_route = pwdata[7:0] & TIMER_ROUTE_MASK;
                ADDR_SERIAL_ROUTE: next_serial_route = pwdata[7:0] & SERIAL_ROUTE_MASK;
                ADDR_PE_HIGH:      next_pe_high = pwdata[7:0] & PE_HIGH_MASK;
                ADDR_WAKE_EN:      next_wake_enable = pwdata[7:0];
                default:           next_wake_enable = wake_enable;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            port_f_low_function_select  <= SELECT_RESET;
            port_f_high_function_select <= SELECT_RESET;
            timer_input_pin_routing     <= SELECT_RESET;
            serial_input_pin_routing    <= SELECT_RESET;
            port_e_high_function_select <= SELECT_RESET;
            wake_enable                 <= SELECT_RESET;
        end else begin
            port_f_low_function_select  <= next_pf_low;
            port_f_high_function_select <= next_pf_high;
            timer_input_pin_routing     <= next_timer_route;
            serial_input_pin_routing    <= next_serial_route;
            port_e_high_function_select <= next_pe_high;
            wake_enable                 <= next_wake_enable;
        end
    end

    // port write strobes; a bit op names its port in its own field
    always_comb begin
        for (int p = 0; p < PORT_COUNT; p++) begin
            wr_data[p] = wr_en && port_hit && (port_idx == 2'(p)) && (paddr[3:0] == PORT_DATA_OFS);
            wr_ctrl[p] = wr_en && port_hit && (port_idx == 2'(p)) && (paddr[3:0] == PORT_CTRL_OFS);
            bit_op[p]  = wr_en && (paddr == ADDR_BIT_OP)
                         && (pwdata[BIT_OP_PORT_LSB +: 2] == 2'(p));
        end
    end

    // ---- port f function decode ----
    assign f3_code = port_f_low_function_select[F3_SEL_LSB +: 2];
    assign f2_code = port_f_low_function_select[F2_SEL_LSB +: 2];
    assign f1_code = port_f_low_function_select[F1_SEL_LSB +: 2];
    assign f0_code = port_f_low_function_select[F0_SEL_LSB +: 2];

    assign lcd_segment_24_en           = (f3_code == CODE_LCD);
    assign analog_input_7_en           = (f3_code == CODE_ANALOG);
    assign lcd_segment_23_en           = (f2_code == CODE_LCD);
    assign analog_input_6_en           = (f2_code == CODE_ANALOG);
    assign analog_input_5_en           = (f1_code == CODE_ANALOG);
    assign opamp_noninverting_input_en = (f1_code == CODE_OPAMP);
    assign analog_input_4_en           = (f0_code == CODE_ANALOG);
    assign opamp_inverting_input_en    = (f0_code == CODE_OPAMP);

    // digital drive is released on pins taken by an alternate function;
    // port f pins 4 to 6 lose it on code 01, the only non-gpio code there
    always_comb begin
        gpio_enable                 = '1;
        gpio_enable[PORT_F][3]      = is_gpio(f3_code, 1'b1);
        gpio_enable[PORT_F][2]      = is_gpio(f2_code, 1'b1);
        gpio_enable[PORT_F][1]      = is_gpio(f1_code, 1'b0);
        gpio_enable[PORT_F][0]      = is_gpio(f0_code, 1'b0);
        for (int b = 0; b < 3; b++) begin
            gpio_enable[PORT_F][4 + b] = (port_f_high_function_select[2 * b +: 2] != CODE_LCD);
        end
    end

    // ---- alternate input routing from synchronised pin levels ----
    assign timer1_capture_input  = timer_input_pin_routing[TIMER1_CAPTURE_POS]
                                   ? pin_level[PORT_C][0] : pin_level[PORT_A][3];
    assign timer2_external_clock = timer_input_pin_routing[TIMER2_CLOCK_POS]
                                   ? pin_level[PORT_A][7] : pin_level[PORT_C][3];
    assign serial_data_input     = serial_input_pin_routing[SERIAL_DATA_POS]
                                   ? pin_level[PORT_B][3] : pin_level[PORT_A][6];
    assign serial_clock_input    = serial_input_pin_routing[SERIAL_CLOCK_POS]
                                   ? pin_level[PORT_B][2] : pin_level[PORT_A][5];

    // ---- ports ----
    for (genvar g = 0; g < PORT_COUNT; g++) begin : g_port
        port_bank #(.WIDTH(PORT_WIDTH)) u_port (
            .clk          (clk),
            .resetn       (resetn),
            .pin_in       (port_pin_in[g]),
            .gpio_enable  (gpio_enable[g]),
            .wr_data      (wr_data[g]),
            .wr_ctrl      (wr_ctrl[g]),
            .wr_value     (pwdata[PORT_WIDTH-1:0]),
            .bit_op       (bit_op[g]),
            .bit_op_ctrl  (pwdata[BIT_OP_CTRL_POS]),
            .bit_op_index (pwdata[2:0]),
            .bit_op_value (pwdata[BIT_OP_VALUE_POS]),
            .data         (port_data[g]),
            .ctrl         (port_ctrl[g]),
            .pin_level    (pin_level[g]),
            .pin_out      (port_pin_out[g]),
            .pin_oe_n     (port_pin_oe_n[g])
        );
    end

    wake_detect #(.WIDTH(PORT_WIDTH)) u_wake (
        .clk         (clk),
        .resetn      (resetn),
        .pin_level   (pin_level[PORT_A]),
        .wake_enable (wake_enable),
        .low_power   (low_power),
        .wake        (wake)
    );

    // ---- checks ----
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_f3_lcd_select: assert property (
        (wr_en && paddr == ADDR_PF_LOW && pwdata[7:6] == 2'h1)
        |=> lcd_segment_24_en && !analog_input_7_en && port_pin_oe_n[PORT_F][3])
        else $error("port f.3 code 01 did not select lcd segment");
    chk_f2_gpio_codes: assert property (
        (wr_en && paddr == ADDR_PF_LOW && pwdata[5:4] == 2'h3)
        |=> !lcd_segment_23_en && !analog_input_6_en && gpio_enable[PORT_F][2])
        else $error("port f.2 code 11 not gpio");
    chk_f1_opamp_select: assert property (
        (wr_en && paddr == ADDR_PF_LOW && pwdata[3:2] == 2'h3)
        |=> opamp_noninverting_input_en && !analog_input_5_en && !gpio_enable[PORT_F][1])
        else $error("port f.1 code 11 not opamp input");
    chk_f0_analog_select: assert property (
        (wr_en && paddr == ADDR_PF_LOW && pwdata[1:0] == 2'h2)
        |=> analog_input_4_en && !opamp_inverting_input_en && !gpio_enable[PORT_F][0])
        else $error("port f.0 code 10 not analog input");
    chk_timer1_route: assert property (
        (wr_en && paddr == ADDR_TIMER_ROUTE && pwdata[6])
        |=> timer1_capture_input == pin_level[PORT_C][0])
        else $error("timer 1 capture not taken from port c.0");
    chk_timer2_route: assert property (
        (wr_en && paddr == ADDR_TIMER_ROUTE && !pwdata[3])
        |=> timer2_external_clock == pin_level[PORT_C][3])
        else $error("timer 2 clock not taken from port c.3");
    chk_serial_data_route: assert property (
        (wr_en && paddr == ADDR_SERIAL_ROUTE && pwdata[5])
        |=> serial_data_input == pin_level[PORT_B][3])
        else $error("serial data not taken from port b.3");
    chk_serial_clock_route: assert property (
        (wr_en && paddr == ADDR_SERIAL_ROUTE && !pwdata[4])
        |=> serial_clock_input == pin_level[PORT_A][5])
        else $error("serial clock not taken from port a.5");
    chk_reserved_read_zero: assert property (
        (wr_en && paddr == ADDR_PF_LOW && pwdata[1:0] == 2'h1)
        |=> gpio_enable[PORT_F][0] && !analog_input_4_en && !opamp_inverting_input_en
            && (timer_input_pin_routing[5:4] == 2'h0) && (port_f_high_function_select[7:6] == 2'h0))
        else $error("reserved code or bits misbehave");
endmodule : pin_function_select
`default_nettype wire

// File: verilog/port_bank.sv
// one i/o port: data latch, direction control, pin sync
// assumes pins are asynchronous and a bus master gives one-cycle write strobes
`timescale 1ns/1ps
`default_nettype none
module port_bank
    import pin_mux_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] pin_in,
    input  wire logic [WIDTH-1:0] gpio_enable,
    input  wire logic             wr_data,
    input  wire logic             wr_ctrl,
    input  wire logic [WIDTH-1:0] wr_value,
    input  wire logic             bit_op,
    input  wire logic             bit_op_ctrl,
    input  wire logic [2:0]       bit_op_index,
    input  wire logic             bit_op_value,
    output logic      [WIDTH-1:0] data,
    output logic      [WIDTH-1:0] ctrl,
    output logic      [WIDTH-1:0] pin_level,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe_n
);
    logic [WIDTH-1:0] pin_meta;
    logic [WIDTH-1:0] next_data;
    logic [WIDTH-1:0] next_ctrl;
    logic [WIDTH-1:0] rmw_word;
    logic             data_touched; // latch written since reset
    logic             next_touched;

    initial begin
        if (WIDTH < 1 || WIDTH > 8) $error("port_bank WIDTH must be 1 to 8");
    end

    // bit op rewrites the whole byte; on the data latch the source is the
    // pin level, so input pins get their sampled level copied into the latch
    always_comb begin
        rmw_word = bit_op_ctrl ? ctrl : pin_level;
        rmw_word[bit_op_index] = bit_op_value;
        next_data = data;
        next_ctrl = ctrl;
        next_touched = data_touched | wr_data | (bit_op && !bit_op_ctrl);
        if (wr_data) next_data = wr_value;
        if (wr_ctrl) next_ctrl = wr_value;
        if (bit_op && !bit_op_ctrl) next_data = rmw_word;
        if (bit_op && bit_op_ctrl) next_ctrl = rmw_word;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            data <= PORT_RESET[WIDTH-1:0];
            ctrl <= PORT_RESET[WIDTH-1:0];
            data_touched <= 1'b0;
        end else begin
            data <= next_data;
            ctrl <= next_ctrl;
            data_touched <= next_touched;
        end
    end

    // two-stage sync; pin_meta feeds only pin_level
    always_ff @(posedge clk) begin
        pin_meta  <= pin_in;
        pin_level <= pin_meta;
    end

    // latch drives the pin directly, so an output with untouched latch is high
    assign pin_out  = data;
    assign pin_oe_n = ctrl | ~gpio_enable;

    default clocking @(posedge clk); endclocking

    chk_reset_all_ones: assert property (
        $past(!resetn) |-> (data == PORT_RESET[WIDTH-1:0]) && (ctrl == PORT_RESET[WIDTH-1:0]))
        else $error("port not all ones after reset");
    chk_output_default_high: assert property (disable iff (!resetn)
        (!data_touched && !ctrl[0] && gpio_enable[0])
        |-> (pin_out[0] && !pin_oe_n[0]))
        else $error("fresh output pin not driven high");
    chk_rmw_whole_byte: assert property (disable iff (!resetn)
        (bit_op && !bit_op_ctrl && !wr_data)
        |=> data == (($past(pin_level) & ~(WIDTH'(1) << $past(bit_op_index)))
                    | (WIDTH'($past(bit_op_value)) << $past(bit_op_index))))
        else $error("bit op did not rewrite port byte");
endmodule : port_bank
`default_nettype wire

// File: verilog/wake_detect.sv
// falling-edge wake detector for port a
// assumes pin_level is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module wake_detect
    import pin_mux_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] pin_level,
    input  wire logic [WIDTH-1:0] wake_enable,
    input  wire logic             low_power,
    output logic                  wake
);
    logic [WIDTH-1:0] pin_prev;
    logic             next_wake;

    initial begin
        if (WIDTH < 1) $error("wake_detect WIDTH must be positive");
    end

    // any enabled pin going high to low counts, only while asleep or idle
    always_comb begin
        next_wake = low_power && |(pin_prev & ~pin_level & wake_enable);
    end

    // prev starts high, so a pin held low through reset looks like a fall on the first cycle after it
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_prev <= {WIDTH{1'b1}};
            wake     <= 1'b0;
        end else begin
            pin_prev <= pin_level;
            wake     <= next_wake;
        end
    end

    default clocking @(posedge clk); endclocking

    chk_wake_on_fall: assert property (disable iff (!resetn)
        ##1 (low_power && |($past(pin_level) & ~pin_level & wake_enable)) |=> wake)
        else $error("enabled falling edge missed while asleep");
    chk_wake_has_cause: assert property (disable iff (!resetn)
        ##2 wake |-> $past(low_power) && |($past(pin_level, 2) & ~$past(pin_level) & $past(wake_enable)))
        else $error("wake without enabled falling edge");
endmodule : wake_detect
`default_nettype wire
